/* design/sfb_pkg.sv */
// Constants shared by the supply fault detector bank
package sfb_pkg;
	// ****************************************************************
	// Channel layout
	// ****************************************************************
	localparam int NCH = 10;        // Ten input channels
	localparam int NDED = 5;        // Dedicated analog channels 0..4
	localparam int NDUAL = 5;       // Dual-function channels 5..9
	localparam int NDET = NCH + NDUAL; // Primary plus warning detectors
	localparam int CH_HIGH = 4;     // High range input channel index
	localparam int CODE_MAX = 255;  // Full-scale threshold code
	localparam int HYST_MAX = 31;   // Largest hysteresis code

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
	localparam int GLITCH_MAX_US = 100;
	localparam int GCNT_W = 14;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] CH_STRIDE = 8'h08;
	localparam logic [7:0] OFS_CH_CFG = 8'h00;   // Word 0 of a channel
	localparam logic [7:0] OFS_CH_GF = 8'h04;    // Word 1 of a channel
	localparam logic [7:0] OFS_STATUS = 8'h50;
	localparam logic [7:0] OFS_EVT = 8'h54;
	localparam logic [7:0] OFS_EVT_CLR = 8'h58;
	localparam logic [7:0] OFS_EVT_EN = 8'h5C;

	// Channel word 0 fields
	localparam int F_UVTH = 0;
	localparam int F_OVTH = 8;
	localparam int F_HYST = 16;
	localparam int F_MODE = 21;
	localparam int F_RANGE = 23;
	localparam int F_LOGIC = 25;
	// Status fields
	localparam int F_FAULT = 0;
	localparam int F_WARN = 10;
	localparam int F_LVIN = 15;

	// Reset values
	localparam logic [7:0] RST_UVTH = 8'h00;
	localparam logic [7:0] RST_OVTH = 8'hFF;
	localparam logic [4:0] RST_HYST = 5'h00;
	localparam logic [6:0] RST_GF = 7'h00;

	// ****************************************************************
	// Modes and ranges
	// ****************************************************************
	typedef enum logic [1:0] {
		SFB_OFF = 2'b00,
		SFB_UNDER = 2'b01,
		SFB_OVER = 2'b10,
		SFB_WINDOW = 2'b11
	} sfb_mode_e;

	// Range 0: 0.573+0.802, 1: 1.25+1.75, 2: 2.5+3.5, 3: 6.0+8.4 volts
	localparam logic [1:0] RNG_LOW = 2'h0;
	localparam logic [1:0] RNG_MID = 2'h1;
	localparam logic [1:0] RNG_HIGH = 2'h2;
	localparam logic [1:0] RNG_TOP = 2'h3;
endpackage

/* design/sfb_supply_fault_detector.sv */
// Ten channel supply fault detector bank with AHB-Lite registers
//
// Behaviour
// - Ten channels; five dual-function ones are analog or logic, not both.
// - Each analog channel flags under, over or out-of-window faults.
// - Under and over thresholds are 8-bit codes per channel.
// - Code N means range bottom plus span times N over 255.
// - Four ranges: 0.573/0.802, 1.25/1.75, 2.5/3.5, 6.0/8.4 volts.
// - High two top ranges, positive three low, dual lowest; filter to 100us.
// - Both comparators evaluate continuously with programmable hysteresis.
// - Active under fault clears only above threshold plus hysteresis.
// - Active over fault clears only below threshold minus hysteresis.
// - Hysteresis is a 5-bit code up to 31, span times code over 255.
// - Glitch filter drops pulses shorter than timeout, delays longer ones.
// - Logic-mode dual channel becomes warning detector on its paired input.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

module sfb_supply_fault_detector #(
	parameter int CYC_PER_US = sfb_pkg::CYC_PER_US
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] supply_level [sfb_pkg::NCH],
	input wire logic [sfb_pkg::NDUAL-1:0] dual_function_input,
	output logic [sfb_pkg::NCH-1:0] fault_flag,
	output logic [sfb_pkg::NDUAL-1:0] warn_flag,
	output logic irq
);
	import sfb_pkg::*;

	// Assertions below all run on the bus clock and pause in reset
	default clocking a_clk @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Clamp a range code to what the channel's attenuator offers
	function automatic logic [1:0] legal_range(input int ch,
		input logic [1:0] r);
		logic [1:0] res;
		res = r;
		if (ch == CH_HIGH) begin
			if (r < RNG_HIGH) res = RNG_HIGH;
		end else if (ch < NDED) begin
			if (r > RNG_HIGH) res = RNG_HIGH;
		end else begin
			res = RNG_LOW;
		end
		return res;
	endfunction

	// Configuration channel that drives a detector
	function automatic int cfg_of(input int d);
		return (d < NCH) ? d : d - NCH + NDED;
	endfunction

	// Level channel that a detector watches
	function automatic int lvl_of(input int d);
		return (d < NCH) ? d : d - NCH;
	endfunction

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [7:0] lvl_m [NCH];
	logic [7:0] lvl_s [NCH];
	logic [NDUAL-1:0] din_m;
	logic [NDUAL-1:0] din_s;

	// Levels come from another domain, so two flops before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NCH; i++) begin
				lvl_m[i] <= 8'h00;
				lvl_s[i] <= 8'h00;
			end
			din_m <= '0;
			din_s <= '0;
		end else begin
			lvl_m <= supply_level;
			lvl_s <= lvl_m;
			din_m <= dual_function_input;
			din_s <= din_m;
		end
	end

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	logic [7:0] uvth_q [NCH];
	logic [7:0] ovth_q [NCH];
	logic [4:0] hyst_q [NCH];
	sfb_mode_e mode_q [NCH];
	logic [1:0] rng_q [NCH];
	logic [6:0] gf_q [NCH];
	logic [NDUAL-1:0] logic_sel_q;
	logic [NDET-1:0] evt_q;
	logic [NDET-1:0] evt_en_q;
	logic [NDET-1:0] filt_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_d;
	logic [NDET-1:0] clr_mask;
	logic [NDET-1:0] evt_set;

	assign hreadyout = 1'b1; // Zero wait states
	assign hresp = 1'b0;     // Always OKAY
	assign fault_flag = filt_q[NCH-1:0];
	assign warn_flag = filt_q[NDET-1:NCH];
	assign irq = |(evt_q & evt_en_q);

	// Capture a write address phase for use in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= hsel & htrans[1] & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// Read decode in the address phase; unmapped words read zero
	always_comb begin
		int c;
		c = int'(haddr[7:3]);
		rdata_d = 32'h0000_0000;
		if (haddr[7:0] < OFS_STATUS) begin
			if (haddr[2:0] == OFS_CH_CFG[2:0]) begin
				rdata_d[F_UVTH +: 8] = uvth_q[c];
				rdata_d[F_OVTH +: 8] = ovth_q[c];
				rdata_d[F_HYST +: 5] = hyst_q[c];
				rdata_d[F_MODE +: 2] = mode_q[c];
				rdata_d[F_RANGE +: 2] = rng_q[c];
				if (c >= NDED) rdata_d[F_LOGIC] = logic_sel_q[c - NDED];
			end else if (haddr[2:0] == OFS_CH_GF[2:0]) begin
				rdata_d[6:0] = gf_q[c];
			end
		end else if (haddr[7:0] == OFS_STATUS) begin
			rdata_d[F_FAULT +: NCH] = filt_q[NCH-1:0];
			rdata_d[F_WARN +: NDUAL] = filt_q[NDET-1:NCH];
			rdata_d[F_LVIN +: NDUAL] = din_s & logic_sel_q;
		end else if (haddr[7:0] == OFS_EVT) begin
			rdata_d[NDET-1:0] = evt_q;
		end else if (haddr[7:0] == OFS_EVT_EN) begin
			rdata_d[NDET-1:0] = evt_en_q;
		end
	end

	// Read data registered so it stands during the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rdata_d;
		end
	end

	// Channel configuration writes, clamped to legal values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NCH; i++) begin
				uvth_q[i] <= RST_UVTH;
				ovth_q[i] <= RST_OVTH;
				hyst_q[i] <= RST_HYST;
				mode_q[i] <= SFB_OFF;
				rng_q[i] <= (i == CH_HIGH) ? RNG_HIGH : RNG_LOW;
				gf_q[i] <= RST_GF;
			end
			logic_sel_q <= '0;
			evt_en_q <= '0;
		end else if (wr_pend_q) begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_addr_q == OFS_CH_CFG + CH_STRIDE * 8'(i)) begin
					uvth_q[i] <= hwdata[F_UVTH +: 8];
					ovth_q[i] <= hwdata[F_OVTH +: 8];
					hyst_q[i] <= hwdata[F_HYST +: 5];
					mode_q[i] <= sfb_mode_e'(hwdata[F_MODE +: 2]);
					rng_q[i] <= legal_range(i, hwdata[F_RANGE +: 2]);
					if (i >= NDED) begin
						logic_sel_q[i - NDED] <= hwdata[F_LOGIC];
					end
				end
				if (wr_addr_q == OFS_CH_GF + CH_STRIDE * 8'(i)) begin
					// Timeouts beyond the limit saturate
					if (hwdata[6:0] > 7'(GLITCH_MAX_US)) begin
						gf_q[i] <= 7'(GLITCH_MAX_US);
					end else begin
						gf_q[i] <= hwdata[6:0];
					end
				end
			end
			if (wr_addr_q == OFS_EVT_EN) evt_en_q <= hwdata[NDET-1:0];
		end
	end

	// ****************************************************************
	// Comparators with hysteresis
	// ****************************************************************
	logic [NDET-1:0] uv_q;
	logic [NDET-1:0] ov_q;
	logic [NDET-1:0] det_on;
	logic [NDET-1:0] raw;

	// Dual channel feeds its own pin or the paired input, never both
	always_comb begin
		for (int d = 0; d < NDET; d++) begin
			if (d < NDED) begin
				det_on[d] = 1'b1;
			end else if (d < NCH) begin
				det_on[d] = !logic_sel_q[d - NDED];
			end else begin
				det_on[d] = logic_sel_q[d - NCH];
			end
		end
	end

	// Compare codes on the threshold scale every clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uv_q <= '0;
			ov_q <= '0;
		end else begin
			for (int d = 0; d < NDET; d++) begin
				int c;
				int l;
				c = cfg_of(d);
				l = lvl_of(d);
				if (!det_on[d]) begin
					uv_q[d] <= 1'b0;
					ov_q[d] <= 1'b0;
				end else begin
					// Under: set below, clear above threshold + hyst
					if (lvl_s[l] < uvth_q[c]) begin
						uv_q[d] <= 1'b1;
					end else if ({1'b0, lvl_s[l]} >
						{1'b0, uvth_q[c]} + {4'h0, hyst_q[c]}) begin
						uv_q[d] <= 1'b0;
					end
					// Over: set above, clear below threshold - hyst
					if (lvl_s[l] > ovth_q[c]) begin
						ov_q[d] <= 1'b1;
					end else if ({1'b0, lvl_s[l]} + {4'h0, hyst_q[c]} <
						{1'b0, ovth_q[c]}) begin
						ov_q[d] <= 1'b0;
					end
				end
			end
		end
	end

	// Mode picks which comparator counts as the fault
	always_comb begin
		for (int d = 0; d < NDET; d++) begin
			case (mode_q[cfg_of(d)])
				SFB_UNDER: raw[d] = uv_q[d];
				SFB_OVER: raw[d] = ov_q[d];
				SFB_WINDOW: raw[d] = uv_q[d] | ov_q[d];
				default: raw[d] = 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// Glitch filters
	// ****************************************************************
	logic [GCNT_W-1:0] gcnt_q [NDET];
	logic [GCNT_W-1:0] glim [NDET];

	// Timeout in cycles; zero still costs one cycle of delay
	always_comb begin
		for (int d = 0; d < NDET; d++) begin
			glim[d] = GCNT_W'(int'(gf_q[cfg_of(d)]) * CYC_PER_US);
		end
	end

	// Output follows only after the input held its new value long enough
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_q <= '0;
			for (int d = 0; d < NDET; d++) gcnt_q[d] <= '0;
		end else begin
			for (int d = 0; d < NDET; d++) begin
				if (raw[d] == filt_q[d]) begin
					gcnt_q[d] <= '0; // Short pulse dropped
				end else if (gcnt_q[d] + 1'b1 >= glim[d]) begin
					filt_q[d] <= raw[d];
					gcnt_q[d] <= '0;
				end else begin
					gcnt_q[d] <= gcnt_q[d] + 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Event status and interrupt
	// ****************************************************************
	// New fault or warning edges; set wins over a same-cycle clear
	always_comb begin
		clr_mask = '0;
		if (wr_pend_q && wr_addr_q == OFS_EVT_CLR) clr_mask = hwdata[NDET-1:0];
		evt_set = '0;
		for (int d = 0; d < NDET; d++) begin
			if (raw[d] != filt_q[d] && raw[d] &&
				gcnt_q[d] + 1'b1 >= glim[d]) evt_set[d] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_q <= '0;
		end else begin
			evt_q <= (evt_q & ~clr_mask) | evt_set;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_uv_sets: assert property (lvl_s[0] < uvth_q[0] |=> uv_q[0])
		else $error("under fault not set below threshold");
	a_uv_holds: assert property (uv_q[0] &&
		{1'b0, lvl_s[0]} <= {1'b0, uvth_q[0]} + {4'h0, hyst_q[0]}
		|=> uv_q[0])
		else $error("under fault cleared inside hysteresis band");
	a_ov_holds: assert property (ov_q[0] &&
		{1'b0, lvl_s[0]} + {4'h0, hyst_q[0]} >= {1'b0, ovth_q[0]}
		|=> ov_q[0])
		else $error("over fault cleared inside hysteresis band");
	a_ov_sets: assert property (lvl_s[1] > ovth_q[1] |=> ov_q[1])
		else $error("over fault not set above threshold");
	a_dual_excl: assert property (logic_sel_q[0] ##1
		logic_sel_q[0] |-> !uv_q[NDED] && !ov_q[NDED])
		else $error("dual channel analog and logic at once");
	a_warn_idle: assert property (!logic_sel_q[0] ##1
		!logic_sel_q[0] |-> !uv_q[NCH] && !ov_q[NCH])
		else $error("warning detector active while pin analog");
	a_range_ok: assert property (rng_q[CH_HIGH] >= RNG_HIGH &&
		rng_q[0] <= RNG_HIGH && rng_q[NDED] == RNG_LOW)
		else $error("channel range outside its attenuator set");
	a_window_or: assert property (mode_q[2] == SFB_WINDOW &&
		gf_q[2] == 7'h00 && (uv_q[2] || ov_q[2]) |=> filt_q[2])
		else $error("window fault missing a component");
	a_glitch_wait: assert property ($rose(filt_q[3]) |->
		$past(gcnt_q[3]) + 1'b1 >= $past(glim[3]))
		else $error("filter output changed before timeout");
	a_evt_sticky: assert property (evt_q[0] && !clr_mask[0]
		|=> evt_q[0])
		else $error("event bit lost without clear");
endmodule

/* verification/sfb_rail_model.sv */
// Model of the supervised rails that feed the detector bank
`timescale 1ns/1ps

// ****************************************************************
// Rail model
// ****************************************************************
module sfb_rail_model (
	input wire logic hclk,
	output logic [7:0] level [sfb_pkg::NCH],
	output logic [sfb_pkg::NDUAL-1:0] dual_in
);
	import sfb_pkg::*;

	// Mid-scale rails and low logic pins until the bench moves them
	initial begin
		for (int i = 0; i < NCH; i++) begin
			level[i] = 8'h80;
		end
		dual_in = '0;
	end

	// A rail level is a code on the threshold scale, held until changed
	task automatic set_level(input int ch, input logic [7:0] v);
		@(posedge hclk);
		level[ch] <= v;
	endtask

	// Dual pins act as plain logic levels when not used as detectors
	task automatic set_dual(input logic [NDUAL-1:0] v);
		@(posedge hclk);
		dual_in <= v;
	endtask
endmodule

/* verification/supply_fault_detector_bank_bench.sv */
// Self-checking bench for the supply fault detector bank
`timescale 1ns/1ps

module supply_fault_detector_bank_bench;
	import sfb_pkg::*;

	localparam int CPU = 2; // Short microsecond keeps glitch runs brief
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, d, rnd;
	logic [1:0] htrans;
	logic [7:0] level [NCH];
	logic [NDUAL-1:0] dual_in, warn_flag;
	logic [NCH-1:0] fault_flag;
	logic [7:0] uth, oth, lv;
	logic uv_st, ov_st;
	int err_count, checked;

	assign hready = hreadyout;

	sfb_supply_fault_detector #(.CYC_PER_US(CPU)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .supply_level(level),
		.dual_function_input(dual_in), .fault_flag(fault_flag),
		.warn_flag(warn_flag), .irq(irq)
	);

	sfb_rail_model rail (.hclk(hclk), .level(level), .dual_in(dual_in));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (err_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One AHB single transfer; waits on hready in both phases
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		xfer(1'b1, a, wd, x);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000, d);
		check(d, exp);
	endtask

	task automatic cfg(input logic [3:0] ch, input logic [7:0] uv, ov,
			input logic [4:0] hy, input logic [1:0] md, input logic lg);
		wr({1'b0, ch, 3'h0}, {6'h00, lg, 2'h0, md, hy, ov, uv});
	endtask

	// Move a rail, let sync, comparator and filter settle, look at flag
	task automatic step(input int ch, input logic [7:0] v, input logic e);
		rail.set_level(ch, v);
		repeat (8) @(posedge hclk);
		check({31'h0, fault_flag[ch]}, {31'h0, e});
	endtask

	// Comparator state update with no hysteresis, strict clear
	function automatic logic uv_next(input logic c, input logic [7:0] l, t);
		return c ? !(l > t) : (l < t);
	endfunction

	function automatic logic ov_next(input logic c, input logic [7:0] l, t);
		return c ? !(l < t) : (l > t);
	endfunction

	// ****************************************************************
	// Clock, reset and watchdog
	// ****************************************************************
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial begin
		repeat (30000) @(posedge hclk);
		err_count++;
		give_verdict();
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = '0;
		err_count = 0;
		checked = 0;
		rnd = 32'h000170F8;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values of channel words; the high input starts in range 2, RNG_HIGH
		rdchk(8'h00, 32'h0000FF00);
		rdchk(8'h20, 32'h0100FF00);
		check({31'h0, hresp}, 32'h0);
		check({31'h0, hreadyout}, 32'h1);
		// Range codes clamp to what each channel offers
		wr(8'h00, 32'h01800000);
		rdchk(8'h00, 32'h01000000);
		wr(8'h28, 32'h01800000);
		rdchk(8'h28, 32'h00000000);
		// Filter timeout saturates at its documented maximum
		wr(8'h04, 32'h0000007F);
		rdchk(8'h04, 32'h00000064);
		wr(8'h04, 32'h00000000);
		rdchk(8'h60, 32'h00000000);
		wr(OFS_EVT_EN, 32'h00007FFF);
		rdchk(OFS_EVT_EN, 32'h00007FFF);
		// Under fault: hysteresis 4 above threshold, strict clear
		cfg(0, 8'h80, 8'hFF, 5'h04, SFB_UNDER, 1'b0);
		step(0, 8'h90, 1'b0);
		step(0, 8'h7F, 1'b1);
		step(0, 8'h84, 1'b1);
		step(0, 8'h85, 1'b0);
		// Sticky event drives irq until cleared
		xfer(1'b0, OFS_EVT, 32'h0, d);
		check({31'h0, d[0]}, 32'h1);
		check({31'h0, irq}, 32'h1);
		wr(OFS_EVT_CLR, 32'h00007FFF);
		@(posedge hclk);
		check({31'h0, irq}, 32'h0);
		// Over fault: hysteresis 3 below threshold
		cfg(1, 8'h00, 8'h40, 5'h03, SFB_OVER, 1'b0);
		step(1, 8'h30, 1'b0);
		step(1, 8'h41, 1'b1);
		step(1, 8'h3D, 1'b1);
		step(1, 8'h3C, 1'b0);
		// Window fault on either side
		cfg(2, 8'h20, 8'hE0, 5'h00, SFB_WINDOW, 1'b0);
		step(2, 8'h10, 1'b1);
		step(2, 8'h80, 1'b0);
		step(2, 8'hF0, 1'b1);
		step(2, 8'h80, 1'b0);
		// Largest hysteresis code
		cfg(0, 8'h80, 8'hFF, 5'h1F, SFB_UNDER, 1'b0);
		rdchk(8'h00, 32'h003FFF80);
		step(0, 8'h7F, 1'b1);
		step(0, 8'h9F, 1'b1);
		step(0, 8'hA0, 1'b0);
		// Glitch filter, 2 us at two cycles each: four cycles
		cfg(3, 8'h80, 8'hFF, 5'h00, SFB_UNDER, 1'b0);
		wr(8'h1C, 32'h00000002);
		step(3, 8'h90, 1'b0);
		rail.set_level(3, 8'h10);
		repeat (2) @(posedge hclk);
		rail.set_level(3, 8'h90);
		repeat (12) @(posedge hclk);
		check({31'h0, fault_flag[3]}, 32'h0);
		rail.set_level(3, 8'h10);
		repeat (12) @(posedge hclk);
		check({31'h0, fault_flag[3]}, 32'h1);
		// Dual channel as logic input; its detector warns on rail 0
		rail.set_dual(5'h01);
		cfg(5, 8'h80, 8'hFF, 5'h00, SFB_UNDER, 1'b1);
		step(5, 8'h10, 1'b0);
		step(0, 8'h70, 1'b1);
		check({27'h0, warn_flag}, 32'h00000001);
		xfer(1'b0, OFS_STATUS, 32'h0, d);
		check({27'h0, d[19:15]}, 32'h00000001);
		check({27'h0, d[14:10]}, 32'h00000001);
		// Random levels and thresholds in each enabled mode on channel 6
		uv_st = 1'b0;
		ov_st = 1'b0;
		lv = 8'h80;
		for (int m = 1; m < 4; m++) begin
			rnd = lfsr(rnd);
			uth = rnd[7:0] & 8'h7F;
			oth = rnd[15:8] | 8'h80;
			cfg(6, uth, oth, 5'h00, SFB_OFF, 1'b0);
			step(6, 8'h00, 1'b0);
			// Comparators keep running while the mode is off
			uv_st = uv_next(uv_next(uv_st, lv, uth), 8'h00, uth);
			ov_st = ov_next(ov_next(ov_st, lv, oth), 8'h00, oth);
			cfg(6, uth, oth, 5'h00, m[1:0], 1'b0);
			for (int i = 0; i < 16; i++) begin
				rnd = lfsr(rnd);
				lv = (i == 0) ? uth : rnd[7:0];
				uv_st = uv_next(uv_st, lv, uth);
				ov_st = ov_next(ov_st, lv, oth);
				step(6, lv, (m == 1) ? uv_st : (m == 2) ? ov_st
					: (uv_st | ov_st));
			end
		end
		give_verdict();
	end
endmodule
